/* core/clock_gate_pkg.sv */
package clock_gate_pkg;

   // register byte offsets
   localparam logic [12:0] PERIPHERAL_GATE_OFS = 13'h103c;
   localparam logic [12:0] DMA_GATE_OFS        = 13'h1040;
   localparam logic [12:0] CLOCK_DIVIDER_OFS   = 13'h1044;

   // peripheral_gate_control field positions
   localparam int DAC_GATE_BIT        = 31;
   localparam int CALENDAR_ACCESS_BIT = 29;
   localparam int CONVERTER_GATE_BIT  = 27;
   localparam int TPM_TWO_BIT         = 26;
   localparam int TPM_ONE_BIT         = 25;
   localparam int TPM_ZERO_BIT        = 24;
   localparam int PERIODIC_GATE_BIT   = 23;
   localparam int AUDIO_GATE_BIT      = 15;
   localparam int ROUTER_GATE_BIT     = 1;
   localparam int FLASH_GATE_BIT      = 0;

   // dma_gate_control field position
   localparam int DMA_GATE_BIT = 8;

   // clock_divider_control core divider field
   localparam int CORE_DIV_LSB = 28;
   localparam int CORE_DIV_MSB = 31;

   // writable bits; every other bit reads as zero
   localparam logic [31:0] PERIPHERAL_GATE_MASK = 32'haf80_8003;
   localparam logic [31:0] DMA_GATE_MASK        = 32'h0000_0100;
   localparam logic [31:0] CLOCK_DIVIDER_MASK   = 32'hf000_0000;

   // values after reset
   localparam logic [31:0] PERIPHERAL_GATE_RST = 32'h0000_0001;
   localparam logic [31:0] DMA_GATE_RST        = 32'h0000_0100;

   // core divider codes loaded from the boot option at reset
   localparam logic [3:0] BOOT_DIV_BY1 = 4'h0;
   localparam logic [3:0] BOOT_DIV_BY2 = 4'h1;
   localparam logic [3:0] BOOT_DIV_BY4 = 4'h3;
   localparam logic [3:0] BOOT_DIV_BY8 = 4'h7;

endpackage

/* core/divider_if.sv */
`timescale 1ns/100ps
`default_nettype none

// carries the divide ratio to the enable generator and its pulse back
interface divider_if #(parameter int DIV_W = 4);
   logic [DIV_W-1:0] ratio;
   logic             tick;

   modport ctrl (output ratio, input tick);
   modport gen  (input ratio, output tick);
endinterface

`default_nettype wire

/* core/core_enable_divider.sv */
`timescale 1ns/100ps
`default_nettype none

// one-cycle enable every (ratio + 1) clocks
module core_enable_divider #(
   parameter int DIV_W = 4
) (
   input  wire logic MCLK,
   input  wire logic RST,
   divider_if.gen    div
);

   generate
      if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
         $error("core_enable_divider: DIV_W out of range");
      end
   endgenerate

   logic [DIV_W-1:0] count_r;
   logic             tick_r;

   ////////////////////////////////////////////////////////////////////////////
   // count up to the ratio, then pulse; a lowered ratio below the count
   // wraps at once rather than running the full width
   always_ff @(posedge MCLK) begin
      if (RST) begin
         count_r <= '0;
         tick_r  <= 1'b0;
      end else if (count_r >= div.ratio) begin
         count_r <= '0;
         tick_r  <= 1'b1;
      end else begin
         count_r <= count_r + 1'b1;
         tick_r  <= 1'b0;
      end
   end

   assign div.tick = tick_r;

endmodule // core_enable_divider

`default_nettype wire

/* core/peripheral_clock_gating.sv */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - bit 31 of peripheral gate enables the dac clock.
// - bit 29 allows calendar access and passes its interrupt.
// - bit 27 enables the analog converter clock.
// - bits 26, 25, 24 enable timer/pwm two, one, zero clocks.
// - bit 23 enables the periodic timer clock.
// - bit 15 enables the audio serial clock.
// - bit 1 enables the dma request router clock.
// - bit 0 gates flash clock; gated flash blocks low-power entry.
// - reserved bits of both gate registers are read-only zero.
// - bit 8 of dma gate enables the dma controller clock.
// - divider register ignores writes in very-low-power run mode.
// - at reset the core divider loads 0000/0001/0011/0111 from boot option.
// - core divider bits 31..28 divide core clocks by value plus one.
module peripheral_clock_gating #(
   parameter int DIV_W = 4
) (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic [12:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic        VERY_LOW_POWER_RUN_MODE,
   input  wire logic [1:0]  BOOT_DIVIDER_OPTION,
   input  wire logic        CALENDAR_IRQ_IN,
   output logic             CALENDAR_IRQ,
   output logic             CALENDAR_ACCESS_EN,
   output logic             DAC_CLOCK_GATE,
   output logic             CONVERTER_CLOCK_GATE,
   output logic             TIMER_PWM_TWO_GATE,
   output logic             TIMER_PWM_ONE_GATE,
   output logic             TIMER_PWM_ZERO_GATE,
   output logic             PERIODIC_TIMER_GATE,
   output logic             AUDIO_SERIAL_GATE,
   output logic             REQUEST_ROUTER_GATE,
   output logic             FLASH_CLOCK_GATE,
   output logic             LOW_POWER_ENTRY_BLOCK,
   output logic             DMA_CLOCK_GATE,
   output logic      [3:0]  CORE_CLOCK_DIVIDER,
   output logic             CORE_CLOCK_EN
);

   generate
      if (DIV_W != 4) begin : g_bad_width
         $error("peripheral_clock_gating: core divider field is four bits");
      end
   endgenerate

   logic [31:0] pgate_r;
   logic [31:0] pgate_nxt;
   logic [31:0] dgate_r;
   logic [31:0] dgate_nxt;
   logic [3:0]  core_div_r;
   logic [3:0]  boot_code;
   logic        lp_block_r;
   logic        cal_irq_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        hit_pgate;
   logic        hit_dgate;
   logic        hit_div;

   divider_if #(.DIV_W(DIV_W)) div ();

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   assign hit_pgate = (ADDR == clock_gate_pkg::PERIPHERAL_GATE_OFS);
   assign hit_dgate = (ADDR == clock_gate_pkg::DMA_GATE_OFS);
   assign hit_div   = (ADDR == clock_gate_pkg::CLOCK_DIVIDER_OFS);

   // boot option to divider code; only the four power-of-two codes occur
   always_comb begin
      unique case (BOOT_DIVIDER_OPTION)
         2'h0: boot_code = clock_gate_pkg::BOOT_DIV_BY1;
         2'h1: boot_code = clock_gate_pkg::BOOT_DIV_BY2;
         2'h2: boot_code = clock_gate_pkg::BOOT_DIV_BY4;
         2'h3: boot_code = clock_gate_pkg::BOOT_DIV_BY8;
      endcase
   end

   // next gate values; masking keeps reserved bits at zero
   always_comb begin
      pgate_nxt = pgate_r;
      dgate_nxt = dgate_r;
      if (WR && hit_pgate) begin
         pgate_nxt = WDATA & clock_gate_pkg::PERIPHERAL_GATE_MASK;
      end
      if (WR && hit_dgate) begin
         dgate_nxt = WDATA & clock_gate_pkg::DMA_GATE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate registers; the enables below are these flops, so each one
   // changes cleanly on the edge that takes the write
   always_ff @(posedge MCLK) begin
      if (RST) begin
         pgate_r <= clock_gate_pkg::PERIPHERAL_GATE_RST;
         dgate_r <= clock_gate_pkg::DMA_GATE_RST;
      end else begin
         pgate_r <= pgate_nxt;
         dgate_r <= dgate_nxt;
      end
   end

   // low-power entry is held off while the flash clock is gated
   always_ff @(posedge MCLK) begin
      if (RST) begin
         lp_block_r <= ~clock_gate_pkg::PERIPHERAL_GATE_RST[clock_gate_pkg::FLASH_GATE_BIT];
      end else begin
         lp_block_r <= ~pgate_nxt[clock_gate_pkg::FLASH_GATE_BIT];
      end
   end

   // core divider: reloaded from the boot option for as long as reset is held
   always_ff @(posedge MCLK) begin
      if (RST) begin
         core_div_r <= boot_code;
      end else if (WR && hit_div && !VERY_LOW_POWER_RUN_MODE) begin
         core_div_r <= WDATA[clock_gate_pkg::CORE_DIV_MSB:clock_gate_pkg::CORE_DIV_LSB];
      end
   end

   // calendar interrupt passes only while access is enabled; costs one
   // cycle of latency to keep the output on a flop
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cal_irq_r <= 1'b0;
      end else begin
         cal_irq_r <= CALENDAR_IRQ_IN & pgate_r[clock_gate_pkg::CALENDAR_ACCESS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_pgate) begin
         rdata_nxt = pgate_r;
      end else if (hit_dgate) begin
         rdata_nxt = dgate_r;
      end else if (hit_div) begin
         rdata_nxt[clock_gate_pkg::CORE_DIV_MSB:clock_gate_pkg::CORE_DIV_LSB] = core_div_r;
      end
   end

   // read data held only in the cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rdata_r <= 32'h0000_0000;
      end else if (RD) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core clock enable pulse
   assign div.ratio = core_div_r;

   core_enable_divider #(.DIV_W(DIV_W)) u_div (
      .MCLK (MCLK),
      .RST  (RST),
      .div  (div)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign RDATA                 = rdata_r;
   assign DAC_CLOCK_GATE        = pgate_r[clock_gate_pkg::DAC_GATE_BIT];
   assign CALENDAR_ACCESS_EN    = pgate_r[clock_gate_pkg::CALENDAR_ACCESS_BIT];
   assign CALENDAR_IRQ          = cal_irq_r;
   assign CONVERTER_CLOCK_GATE  = pgate_r[clock_gate_pkg::CONVERTER_GATE_BIT];
   assign TIMER_PWM_TWO_GATE    = pgate_r[clock_gate_pkg::TPM_TWO_BIT];
   assign TIMER_PWM_ONE_GATE    = pgate_r[clock_gate_pkg::TPM_ONE_BIT];
   assign TIMER_PWM_ZERO_GATE   = pgate_r[clock_gate_pkg::TPM_ZERO_BIT];
   assign PERIODIC_TIMER_GATE   = pgate_r[clock_gate_pkg::PERIODIC_GATE_BIT];
   assign AUDIO_SERIAL_GATE     = pgate_r[clock_gate_pkg::AUDIO_GATE_BIT];
   assign REQUEST_ROUTER_GATE   = pgate_r[clock_gate_pkg::ROUTER_GATE_BIT];
   assign FLASH_CLOCK_GATE      = pgate_r[clock_gate_pkg::FLASH_GATE_BIT];
   assign LOW_POWER_ENTRY_BLOCK = lp_block_r;
   assign DMA_CLOCK_GATE        = dgate_r[clock_gate_pkg::DMA_GATE_BIT];
   assign CORE_CLOCK_DIVIDER    = core_div_r;
   assign CORE_CLOCK_EN         = div.tick;

endmodule // peripheral_clock_gating

`default_nettype wire

/* testbench/peripheral_model.sv */
`timescale 1ns/100ps
`default_nettype none

// stands in for the gated peripherals: a calendar that raises its
// interrupt in a shifting pattern, and a core that counts its enables
module peripheral_model (
   input  wire logic MCLK,
   input  wire logic RST,
   input  wire logic CORE_CLOCK_EN,
   output var  logic CALENDAR_IRQ_IN,
   output var  int   pulse_count
);
   logic [3:0] pat_r;

   // pattern never settles, so a stuck irq path shows quickly
   always_ff @(posedge MCLK) begin
      pat_r           <= RST ? 4'h1 : {pat_r[2:0], pat_r[3] ^ pat_r[2]};
      CALENDAR_IRQ_IN <= pat_r[0] ^ pat_r[3];
      pulse_count     <= RST ? 0 : pulse_count + int'(CORE_CLOCK_EN);
   end
endmodule // peripheral_model

`default_nettype wire

/* testbench/clock_gate_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module clock_gate_properties (
   input wire logic        MCLK, RST, WR, RD, VERY_LOW_POWER_RUN_MODE,
   input wire logic [12:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic [31:0] RDATA,
   input wire logic        CALENDAR_IRQ_IN, CALENDAR_IRQ, CALENDAR_ACCESS_EN, DAC_CLOCK_GATE,
   input wire logic        FLASH_CLOCK_GATE, LOW_POWER_ENTRY_BLOCK, DMA_CLOCK_GATE, CORE_CLOCK_EN,
   input wire logic [3:0]  CORE_CLOCK_DIVIDER
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   ////////////////////////////////////////////////////////////////////
   // divide-by-four: a pulse, three quiet cycles, then the next pulse
   sequence div4_quiet;
      (CORE_CLOCK_EN && CORE_CLOCK_DIVIDER == 4'h3) ##1 (!CORE_CLOCK_EN && CORE_CLOCK_DIVIDER == 4'h3) [*3];
   endsequence

   a_dac_write: assert property (WR && ADDR == 13'h103c |=> DAC_CLOCK_GATE == $past(WDATA[31]))
      else $error("dac gate did not follow write");
   a_calendar_write: assert property (WR && ADDR == 13'h103c |=> CALENDAR_ACCESS_EN == $past(WDATA[29]))
      else $error("calendar access did not follow write");
   a_calendar_irq: assert property (1'b1 |=> CALENDAR_IRQ == ($past(CALENDAR_IRQ_IN) && $past(CALENDAR_ACCESS_EN)))
      else $error("calendar irq not gated by access");
   a_flash_block: assert property (LOW_POWER_ENTRY_BLOCK == !FLASH_CLOCK_GATE)
      else $error("low power block disagrees with flash gate");
   a_dma_write: assert property (WR && ADDR == 13'h1040 |=> DMA_CLOCK_GATE == $past(WDATA[8]))
      else $error("dma gate did not follow write");
   a_divider_lock: assert property (WR && ADDR == 13'h1044 && VERY_LOW_POWER_RUN_MODE |=> $stable(CORE_CLOCK_DIVIDER))
      else $error("divider written in low power run");
   a_divider_write: assert property (WR && ADDR == 13'h1044 && !VERY_LOW_POWER_RUN_MODE
                                     |=> CORE_CLOCK_DIVIDER == $past(WDATA[31:28]))
      else $error("divider did not follow write");
   a_gate_hold: assert property (!(WR && ADDR == 13'h103c) |=> $stable(DAC_CLOCK_GATE))
      else $error("dac gate moved without a write");
   a_reserved_read: assert property (RD && ADDR == 13'h1040 |=> (RDATA & 32'hfffffeff) == 32'h0)
      else $error("reserved dma gate bits read nonzero");
   a_div_period: assert property (div4_quiet |=> CORE_CLOCK_EN)
      else $error("core enable period wrong");
endmodule // clock_gate_properties

bind peripheral_clock_gating clock_gate_properties u_clock_gate_properties (
   .MCLK(MCLK), .RST(RST), .WR(WR), .RD(RD), .VERY_LOW_POWER_RUN_MODE(VERY_LOW_POWER_RUN_MODE),
   .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .CALENDAR_IRQ_IN(CALENDAR_IRQ_IN),
   .CALENDAR_IRQ(CALENDAR_IRQ), .CALENDAR_ACCESS_EN(CALENDAR_ACCESS_EN), .DAC_CLOCK_GATE(DAC_CLOCK_GATE),
   .FLASH_CLOCK_GATE(FLASH_CLOCK_GATE), .LOW_POWER_ENTRY_BLOCK(LOW_POWER_ENTRY_BLOCK),
   .DMA_CLOCK_GATE(DMA_CLOCK_GATE), .CORE_CLOCK_EN(CORE_CLOCK_EN), .CORE_CLOCK_DIVIDER(CORE_CLOCK_DIVIDER));

`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
   logic        MCLK, RST, WR, RD, VERY_LOW_POWER_RUN_MODE, CALENDAR_IRQ_IN, CALENDAR_IRQ, CALENDAR_ACCESS_EN;
   logic        DAC_CLOCK_GATE, CONVERTER_CLOCK_GATE, TIMER_PWM_TWO_GATE, TIMER_PWM_ONE_GATE, TIMER_PWM_ZERO_GATE;
   logic        PERIODIC_TIMER_GATE, AUDIO_SERIAL_GATE, REQUEST_ROUTER_GATE, FLASH_CLOCK_GATE;
   logic        LOW_POWER_ENTRY_BLOCK, DMA_CLOCK_GATE, CORE_CLOCK_EN;
   logic [12:0] ADDR;
   logic [31:0] WDATA, RDATA;
   logic [1:0]  BOOT_DIVIDER_OPTION;
   logic [3:0]  CORE_CLOCK_DIVIDER;
   int          miscompares = 0, checked = 0, pulse_count;

   peripheral_clock_gating u_peripheral_clock_gating (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .VERY_LOW_POWER_RUN_MODE(VERY_LOW_POWER_RUN_MODE),
      .BOOT_DIVIDER_OPTION(BOOT_DIVIDER_OPTION), .CALENDAR_IRQ_IN(CALENDAR_IRQ_IN), .CALENDAR_IRQ(CALENDAR_IRQ),
      .CALENDAR_ACCESS_EN(CALENDAR_ACCESS_EN), .DAC_CLOCK_GATE(DAC_CLOCK_GATE),
      .CONVERTER_CLOCK_GATE(CONVERTER_CLOCK_GATE), .TIMER_PWM_TWO_GATE(TIMER_PWM_TWO_GATE),
      .TIMER_PWM_ONE_GATE(TIMER_PWM_ONE_GATE), .TIMER_PWM_ZERO_GATE(TIMER_PWM_ZERO_GATE),
      .PERIODIC_TIMER_GATE(PERIODIC_TIMER_GATE), .AUDIO_SERIAL_GATE(AUDIO_SERIAL_GATE),
      .REQUEST_ROUTER_GATE(REQUEST_ROUTER_GATE), .FLASH_CLOCK_GATE(FLASH_CLOCK_GATE),
      .LOW_POWER_ENTRY_BLOCK(LOW_POWER_ENTRY_BLOCK), .DMA_CLOCK_GATE(DMA_CLOCK_GATE),
      .CORE_CLOCK_DIVIDER(CORE_CLOCK_DIVIDER), .CORE_CLOCK_EN(CORE_CLOCK_EN));
   peripheral_model u_peripheral_model (.MCLK(MCLK), .RST(RST), .CORE_CLOCK_EN(CORE_CLOCK_EN),
      .CALENDAR_IRQ_IN(CALENDAR_IRQ_IN), .pulse_count(pulse_count));

   ////////////////////////////////////////////////////////////////////
   // expected divider code for each boot option
   function automatic logic [3:0] boot_code(input logic [1:0] o);
      return {1'b0, o == 2'h3, o[1], o != 2'h0};
   endfunction
   // gate outputs placed back at their register positions
   function automatic logic [31:0] gate_vec();
      return {DAC_CLOCK_GATE, 1'b0, CALENDAR_ACCESS_EN, 1'b0, CONVERTER_CLOCK_GATE, TIMER_PWM_TWO_GATE,
              TIMER_PWM_ONE_GATE, TIMER_PWM_ZERO_GATE, PERIODIC_TIMER_GATE, 7'h0, AUDIO_SERIAL_GATE, 13'h0,
              REQUEST_ROUTER_GATE, FLASH_CLOCK_GATE};
   endfunction

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      @(posedge MCLK); WR <= 1'b1; ADDR <= a; WDATA <= d;
      @(posedge MCLK); WR <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [12:0] a, output logic [31:0] q);
      @(posedge MCLK); RD <= 1'b1; ADDR <= a;
      @(posedge MCLK); RD <= 1'b0;
      #1 q = RDATA;
   endtask
   // settle past any counter wrap, then a whole number of periods holds exactly 8 pulses
   task automatic count_pulses(input logic [3:0] d, output int n);
      repeat (2 * (d + 1) + 2) @(posedge MCLK);
      n = pulse_count;
      repeat (8 * (d + 1)) @(posedge MCLK);
      n = pulse_count - n;
   endtask
   task automatic finish_test();
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end

   initial begin
      logic [31:0] q, d, pg, dg, dv;
      logic [12:0] a;
      logic        v;
      int          n;
      RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 13'h0; WDATA = 32'h0;
      VERY_LOW_POWER_RUN_MODE = 1'b0; BOOT_DIVIDER_OPTION = 2'h0;
      q = $urandom(33712);
      // every boot option, each through its own reset
      for (int o = 0; o < 4; o++) begin
         @(posedge MCLK); RST <= 1'b1; BOOT_DIVIDER_OPTION <= o[1:0];
         repeat (10) @(posedge MCLK);
         RST <= 1'b0;
         rd(13'h1044, q); `CHK(q, {boot_code(o[1:0]), 28'h0})
         count_pulses(boot_code(o[1:0]), n); `CHK(n, 8)
      end
      rd(13'h103c, q); `CHK(q, 32'h00000001)
      pg = 32'h1; dg = 32'h100; dv = {boot_code(2'h3), 28'h0};
      // random writes over all three registers and one unmapped word
      for (int i = 0; i < 60; i++) begin
         n = $urandom_range(3);
         a = (n == 0) ? 13'h103c : (n == 1) ? 13'h1040 : (n == 2) ? 13'h1044 : 13'h1048;
         d = (i < 3) ? 32'hffffffff : $urandom;
         v = (i == 2) ? 1'b1 : 1'($urandom_range(1));
         VERY_LOW_POWER_RUN_MODE <= v;
         wr(a, d);
         if (a == 13'h103c) pg = d & 32'haf808003;
         if (a == 13'h1040) dg = d & 32'h00000100;
         if (a == 13'h1044 && !v) dv = d & 32'hf0000000;
         rd(13'h103c, q); `CHK(q, pg)
         rd(13'h1040, q); `CHK(q, dg)
         rd(13'h1044, q); `CHK(q, dv)
         rd(13'h1048, q); `CHK(q, 32'h0)
         `CHK(gate_vec(), pg)
         `CHK({DMA_CLOCK_GATE, CORE_CLOCK_DIVIDER}, {dg[8], dv[31:28]})
      end
      VERY_LOW_POWER_RUN_MODE <= 1'b0;
      wr(13'h1044, 32'hf0000000);
      count_pulses(4'hf, n); `CHK(n, 8)
      finish_test();
   end
endmodule // testbench

`default_nettype wire
